/* File: verif/adc_serial_port_ready_sync_tb.sv */
// Bench joining host controller and device end over the link
`include "asprs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module adc_serial_port_ready_sync_tb;
    import asprs_pkg::*;
    logic mclk_in = 0, sys_rst_in = 1, psel = 0, pen = 0, pwr = 0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pw = 32'h0000_0000, rd;
    logic [15:0] smp_a = 16'h1234;
    wire [31:0] prd;
    wire prdy, irq, hold;
    wire [1:0] mode;
    int n_errors = 0, total_checks = 0;
    always #20 mclk_in = ~mclk_in;
    asprs_link_if lk ();
    asprs_device asprs_device_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .link(lk), .main_sample_in(smp_a), .aux_sample_in(16'h5678),
        .mode_out(mode), .filter_hold_out(hold), .result_strobe_out());
    asprs_host asprs_host_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .link(lk), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(pa), .pwdata_in(pw), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(), .irq_out(irq));
    asprs_link_properties asprs_link_properties_inst (.mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in), .device_select_n(lk.device_select_n),
        .serial_clock(lk.serial_clock), .serial_data_in(lk.serial_data_in),
        .serial_data_out(lk.serial_data_out),
        .device_reset_n(lk.device_reset_n), .filter_sync_n(lk.filter_sync_n),
        .data_ready_n(lk.data_ready_n));
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1; pwr <= w; pa <= a; pw <= d; pen <= 0;
        @(posedge mclk_in);
        pen <= 1;
        do @(posedge mclk_in); while (prdy !== 1'b1);
        rd = prd;
        psel <= 0; pen <= 0;
    endtask
    task automatic wait_st(input int b, input logic v);
        for (int k = 0; k < 3000; k++) begin
            apb(0, `ASPRS_APB_STATUS, 32'h0000_0000);
            if (rd[b] === v) break;
        end
        `CK("wait", v, rd[b])
    endtask
    task automatic xfer(input logic [7:0] c, input logic [15:0] d);
        apb(1, `ASPRS_APB_WDATA, 32'(d));
        apb(1, `ASPRS_APB_CMD, 32'(c));
        wait_st(0, 1'b0);
        apb(0, `ASPRS_APB_RDATA, 32'h0000_0000);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        n_errors++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 0;
        `CK("rdy_idle", 1'b1, lk.data_ready_n)
        apb(1, `ASPRS_APB_IRQ_MASK, 32'h0000_0002);
        // Slow rate so each read frame ends well inside one period
        xfer(8'h02, 16'h00FF);
        `CK("irq_masked", 1'b0, irq)
        xfer(8'h42, 16'h0000);
        `CK("rate", 16'h00FF, rd[15:0])
        xfer(8'h01, 16'h0005);
        `CK("mode", 2'h1, mode)
        wait_st(1, 1'b1);
        `CK("irq_on", 1'b1, irq)
        apb(0, `ASPRS_APB_IRQ_ST, 32'h0000_0000);
        `CK("irq_st", 2'h3, rd[1:0])
        apb(0, `ASPRS_APB_IRQ_ST, 32'h0000_0000);
        `CK("irq_clr", 1'b0, irq)
        xfer(8'h43, 16'h0000);
        `CK("main", 16'h1234, rd[15:0])
        apb(0, `ASPRS_APB_STATUS, 32'h0000_0000);
        `CK("rdy_read", 1'b0, rd[1])
        smp_a <= 16'hA5C3;
        xfer(8'h01, 16'h0006);
        wait_st(1, 1'b1);
        xfer(8'h43, 16'h0000);
        apb(0, `ASPRS_APB_STATUS, 32'h0000_0000);
        `CK("cal_hold", 1'b1, rd[1])
        xfer(8'h45, 16'h0000);
        `CK("coef", 16'hA5C3, rd[15:0])
        xfer(8'h01, 16'h0000);
        apb(0, `ASPRS_APB_STATUS, 32'h0000_0000);
        `CK("cal_free", 1'b0, rd[1])
        apb(1, `ASPRS_APB_PINS, 32'h0000_0002);
        xfer(8'h01, 16'h000D);
        repeat (5000) @(posedge mclk_in);
        apb(0, `ASPRS_APB_STATUS, 32'h0000_0000);
        `CK("sync_rdy", 1'b0, rd[1])
        `CK("sync_hold", 1'b1, hold)
        apb(1, `ASPRS_APB_PINS, 32'h0000_0000);
        wait_st(1, 1'b1);
        `CK("sync_run", 1'b1, rd[1])
        xfer(8'h44, 16'h0000);
        `CK("aux", 16'h5678, rd[15:0])
        apb(1, `ASPRS_APB_PINS, 32'h0000_0001);
        repeat (8) @(posedge mclk_in);
        `CK("rst_rdy", 1'b1, lk.data_ready_n)
        apb(1, `ASPRS_APB_PINS, 32'h0000_0000);
        xfer(8'h42, 16'h0000);
        `CK("rst_rate", 16'h0010, rd[15:0])
        apb(0, 8'h1C, 32'h0000_0000);
        `CK("unmapped", 32'h0000_0000, rd)
        give_verdict;
    end
endmodule
`default_nettype wire

/* File: verif/asprs_link_properties.sv */
// Concurrent checks on the serial link between host and device
`timescale 1ns/1ps
`default_nettype none
module asprs_link_properties (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic device_select_n,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic device_reset_n,
    input wire logic filter_sync_n,
    input wire logic data_ready_n
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    chk_sclk_idle: assert property (
        device_select_n |-> serial_clock) else $error("sclk not idle high");
    chk_sclk_low: assert property (
        $fell(serial_clock) |-> !serial_clock [*4] ##1 serial_clock)
        else $error("sclk low phase length wrong");
    chk_setup_len: assert property (
        $fell(device_select_n) |-> serial_clock [*4] ##1 !serial_clock)
        else $error("select setup length wrong");
    chk_frame_len: assert property (
        $fell(device_select_n) |-> ##199 !device_select_n ##1 device_select_n)
        else $error("frame length wrong");
    chk_sdi_hold: assert property (
        $rose(serial_clock) |-> $stable(serial_data_in) [*4])
        else $error("data moved while sclk high");
    chk_sdi_setup: assert property (
        $fell(serial_clock) |=> $stable(serial_data_in) [*3])
        else $error("data moved inside low phase");
    chk_fall_sel: assert property (
        $fell(serial_clock) |-> !device_select_n)
        else $error("sclk pulse outside select");
    // Six cycles cover the pin synchroniser plus the ready flop
    chk_rst_rdy: assert property (
        !device_reset_n [*6] |-> data_ready_n)
        else $error("ready low under device reset");
    chk_sync_freeze: assert property (
        !filter_sync_n [*6] |-> !$fell(data_ready_n))
        else $error("result while sync held");
endmodule
`default_nettype wire

/* File: verilog/asprs_consts.svh */
// Constants shared by the serial port device end and its host controller
`ifndef ASPRS_CONSTS_SVH
`define ASPRS_CONSTS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ASPRS_MCLK_NS 40
`define ASPRS_SCLK_PERIOD_NS 320
`define ASPRS_SCLK_HALF ((`ASPRS_SCLK_PERIOD_NS / 2) / `ASPRS_MCLK_NS)
`define ASPRS_CAL_CYCLES 16'h0040

// ----------------------------------------------------------------------
// Serial frame: command byte, then one 16-bit data word
// ----------------------------------------------------------------------
`define ASPRS_CMD_READ_BIT 6
`define ASPRS_CMD_LAST 4'h7
`define ASPRS_DATA_LAST 4'hF
`define ASPRS_FRAME_LAST 5'h17
`define ASPRS_FRAME_DATA 5'h08

// ----------------------------------------------------------------------
// Device register selects and fields
// ----------------------------------------------------------------------
`define ASPRS_REG_STATUS 4'h0
`define ASPRS_REG_MODE 4'h1
`define ASPRS_REG_RATE 4'h2
`define ASPRS_REG_MAIN 4'h3
`define ASPRS_REG_AUX 4'h4
`define ASPRS_REG_COEF 4'h5
`define ASPRS_MODE_IDLE 2'h0
`define ASPRS_MODE_CONV 2'h1
`define ASPRS_MODE_CAL 2'h2
`define ASPRS_MODE_MAIN_EN 2
`define ASPRS_MODE_AUX_EN 3
`define ASPRS_RATE_RST 12'h010

// ----------------------------------------------------------------------
// Host controller APB map
// ----------------------------------------------------------------------
`define ASPRS_APB_CMD 8'h00
`define ASPRS_APB_WDATA 8'h04
`define ASPRS_APB_RDATA 8'h08
`define ASPRS_APB_STATUS 8'h0C
`define ASPRS_APB_IRQ_ST 8'h10
`define ASPRS_APB_IRQ_MASK 8'h14
`define ASPRS_APB_PINS 8'h18
`define ASPRS_IRQ_DONE 0
`define ASPRS_IRQ_RDY 1
`define ASPRS_PIN_RESET 0
`define ASPRS_PIN_SYNC 1

`endif

/* File: verilog/asprs_device.sv */
// Converter device end: serial port, registers and data-ready logic
//
// How it works
// - Shifted-in words go to selected register
// - Reset pin returns all state to power-on
// - Serial transfers honoured only while select low
// - Select tied low gives three-wire operation
// - Host uses select per device or per frame
// - Host always supplies the serial clock
// - Continuous or gapped serial clock both accepted
// - Sync low holds filter and calibration in reset
// - Shared sync restarts all devices together
// - Ready low when either converter holds result
// - Ready returns high after full word read
// - Unread result drops ready before next update
// - Ready goes low when calibration finishes
// - Ready pin is NOR of two flags
// - Disabled converter ignored by ready pin
// - After calibration ready stays low until mode write
// - Output shifter loaded from selected register
//
// Decided for this implementation: the register offsets and register access over APB.
`include "asprs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module asprs_device (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    asprs_link_if.dev link,
    input wire logic [15:0] main_sample_in,
    input wire logic [15:0] aux_sample_in,
    output logic [1:0] mode_out,
    output logic filter_hold_out,
    output logic result_strobe_out
);
    import asprs_pkg::*;

    // ------------------------------------------------------------------
    // Power-on state
    // ------------------------------------------------------------------
    function automatic asprs_dev_state_t dev_reset();
        asprs_dev_state_t s;
        s = '0;
        s.rate = `ASPRS_RATE_RST;
        s.main_en = 1'b1;
        s.aux_en = 1'b1;
        s.rdy_n = 1'b1;
        return s;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] pins_s;
    logic sel_n_s;
    logic sclk_s;
    logic sdi_s;
    logic rst_n_s;
    logic sync_n_s;

    asprs_sync2 #(
        .W(5)
    ) u_sync (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({link.device_select_n, link.serial_clock,
                   link.serial_data_in, link.device_reset_n,
                   link.filter_sync_n}),
        .sync_out(pins_s)
    );

    assign sel_n_s = pins_s[4];
    assign sclk_s = pins_s[3];
    assign sdi_s = pins_s[2];
    assign rst_n_s = pins_s[1];
    assign sync_n_s = pins_s[0];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    asprs_dev_state_t st_reg;
    asprs_dev_state_t st_next;
    logic strobe_next;
    logic strobe_reg;

    function automatic logic [15:0] reg_value(asprs_dev_state_t s,
                                              logic [3:0] sel,
                                              logic hold);
        logic [15:0] v;
        v = 16'h0000;
        case (sel)
            `ASPRS_REG_STATUS: begin
                v = {12'h000, hold, s.cal_hold, s.flag_b, s.flag_a};
            end
            `ASPRS_REG_MODE: v = {12'h000, s.aux_en, s.main_en, s.mode};
            `ASPRS_REG_RATE: v = {4'h0, s.rate};
            `ASPRS_REG_MAIN: v = s.main_data;
            `ASPRS_REG_AUX: v = s.aux_data;
            `ASPRS_REG_COEF: v = s.coef;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    always_comb begin
        logic rise;
        logic [15:0] word;
        logic [15:0] limit;
        rise = 1'b0;
        word = 16'h0000;
        limit = {st_reg.rate, 4'hF};
        strobe_next = 1'b0;
        st_next = st_reg;
        st_next.sclk_d = sclk_s;
        if (!rst_n_s) begin
            st_next = dev_reset();
            st_next.sclk_d = sclk_s;
        end else begin
            // ----------------------------------------------------------
            // Serial port; only sampled edges count, so gaps are harmless
            // ----------------------------------------------------------
            rise = sclk_s & ~st_reg.sclk_d;
            word = {st_reg.in_sh[14:0], sdi_s};
            if (sel_n_s) begin
                // Deselect aborts any partial frame
                st_next.phase = ASPRS_PH_CMD;
                st_next.bit_cnt = 4'h0;
                st_next.out_sh = 16'h0000;
            end else if (rise) begin
                // Select held low works as plain three-wire
                st_next.in_sh = word;
                st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                case (st_reg.phase)
                    ASPRS_PH_CMD: begin
                        if (st_reg.bit_cnt == `ASPRS_CMD_LAST) begin
                            st_next.cmd = word[7:0];
                            st_next.phase = ASPRS_PH_DATA;
                            st_next.bit_cnt = 4'h0;
                            st_next.out_sh = 16'h0000;
                            if (word[`ASPRS_CMD_READ_BIT]) begin
                                st_next.out_sh = reg_value(st_reg,
                                    word[3:0], ~sync_n_s);
                            end
                        end
                    end
                    ASPRS_PH_DATA: begin
                        st_next.out_sh = {st_reg.out_sh[14:0], 1'b0};
                        if (st_reg.bit_cnt == `ASPRS_DATA_LAST) begin
                            st_next.phase = ASPRS_PH_CMD;
                            st_next.bit_cnt = 4'h0;
                            if (!st_reg.cmd[`ASPRS_CMD_READ_BIT]) begin
                                case (st_reg.cmd[3:0])
                                    `ASPRS_REG_MODE: begin
                                        st_next.mode = word[1:0];
                                        st_next.main_en =
                                            word[`ASPRS_MODE_MAIN_EN];
                                        st_next.aux_en =
                                            word[`ASPRS_MODE_AUX_EN];
                                        st_next.flag_a = 1'b0;
                                        st_next.flag_b = 1'b0;
                                        st_next.cal_hold = 1'b0;
                                        st_next.conv_cnt = 16'h0000;
                                    end
                                    `ASPRS_REG_RATE: begin
                                        st_next.rate = word[11:0];
                                    end
                                    `ASPRS_REG_COEF: st_next.coef = word;
                                    default: st_next.coef = st_reg.coef;
                                endcase
                            end else if (!st_reg.cal_hold) begin
                                // Full word read releases ready
                                if (st_reg.cmd[3:0] == `ASPRS_REG_MAIN) begin
                                    st_next.flag_a = 1'b0;
                                end
                                if (st_reg.cmd[3:0] == `ASPRS_REG_AUX) begin
                                    st_next.flag_b = 1'b0;
                                end
                            end
                        end
                    end
                    default: st_next.phase = ASPRS_PH_CMD;
                endcase
            end

            // ----------------------------------------------------------
            // Conversion sequencer; runs after the port so a new result
            // wins over a clear in the same cycle
            // ----------------------------------------------------------
            if (!sync_n_s) begin
                st_next.conv_cnt = 16'h0000;
            end else begin
                case (st_next.mode)
                    `ASPRS_MODE_CONV: begin
                        if (st_next.conv_cnt == limit) begin
                            st_next.conv_cnt = 16'h0000;
                            st_next.main_data = main_sample_in;
                            st_next.aux_data = aux_sample_in;
                            st_next.flag_a = st_next.main_en;
                            st_next.flag_b = st_next.aux_en;
                            strobe_next = 1'b1;
                        end else begin
                            if (st_next.conv_cnt == limit - 16'h0001) begin
                                st_next.flag_a = 1'b0;
                                st_next.flag_b = 1'b0;
                            end
                            st_next.conv_cnt = st_next.conv_cnt + 16'h0001;
                        end
                    end
                    `ASPRS_MODE_CAL: begin
                        if (st_next.conv_cnt == `ASPRS_CAL_CYCLES) begin
                            st_next.conv_cnt = 16'h0000;
                            st_next.coef = main_sample_in;
                            st_next.mode = `ASPRS_MODE_IDLE;
                            st_next.flag_a = st_next.main_en;
                            st_next.flag_b = st_next.aux_en;
                            st_next.cal_hold = 1'b1;
                        end else begin
                            st_next.conv_cnt = st_next.conv_cnt + 16'h0001;
                        end
                    end
                    default: st_next.conv_cnt = 16'h0000;
                endcase
            end
        end
        // Disabled converter cannot pull ready low
        st_next.rdy_n = ~((st_next.flag_a & st_next.main_en) |
                          (st_next.flag_b & st_next.aux_en));
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= dev_reset();
            strobe_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            strobe_reg <= strobe_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign link.serial_data_out = st_reg.out_sh[15];
    assign link.data_ready_n = st_reg.rdy_n;
    assign mode_out = st_reg.mode;
    assign filter_hold_out = ~sync_n_s;
    assign result_strobe_out = strobe_reg;
endmodule
`default_nettype wire

/* File: verilog/asprs_host.sv */
// Host controller end: APB registers driving the serial link
`include "asprs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module asprs_host (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    asprs_link_if.host link,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out
);
    import asprs_pkg::*;

    function automatic asprs_host_state_t host_reset();
        asprs_host_state_t s;
        s = '0;
        s.sel_n = 1'b1;
        s.sclk = 1'b1;
        s.reset_n = 1'b1;
        s.sync_n = 1'b1;
        s.rdy_d = 1'b1;
        return s;
    endfunction

    logic [1:0] pins_s;
    logic sdo_s;
    logic rdy_n_s;

    asprs_sync2 #(
        .W(2)
    ) u_sync (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({link.serial_data_out, link.data_ready_n}),
        .sync_out(pins_s)
    );

    assign sdo_s = pins_s[1];
    assign rdy_n_s = pins_s[0];

    asprs_host_state_t st_reg;
    asprs_host_state_t st_next;

    always_comb begin
        logic tick;
        logic acc;
        logic [1:0] ev;
        logic [1:0] clr;
        tick = (st_reg.div == 3'(`ASPRS_SCLK_HALF - 1));
        acc = psel_in & penable_in;
        ev = 2'b00;
        clr = 2'b00;
        st_next = st_reg;
        st_next.div = tick ? 3'h0 : st_reg.div + 3'h1;
        st_next.rdy_d = rdy_n_s;
        if (st_reg.rdy_d & ~rdy_n_s) begin
            ev[`ASPRS_IRQ_RDY] = 1'b1;
        end

        // --------------------------------------------------------------
        // Frame engine: sclk idles high, bit driven on fall, taken on rise
        // --------------------------------------------------------------
        if (tick) begin
            case (st_reg.st)
                ASPRS_H_SETUP: begin
                    st_next.sclk = 1'b0;
                    st_next.sdi = st_reg.tx[23];
                    st_next.st = ASPRS_H_LOW;
                end
                ASPRS_H_LOW: begin
                    st_next.sclk = 1'b1;
                    if (st_reg.idx >= `ASPRS_FRAME_DATA) begin
                        st_next.rx = {st_reg.rx[14:0], sdo_s};
                    end
                    st_next.st = ASPRS_H_HIGH;
                end
                ASPRS_H_HIGH: begin
                    if (st_reg.idx == `ASPRS_FRAME_LAST) begin
                        st_next.st = ASPRS_H_END;
                    end else begin
                        st_next.sclk = 1'b0;
                        st_next.idx = st_reg.idx + 5'h01;
                        st_next.tx = {st_reg.tx[22:0], 1'b0};
                        st_next.sdi = st_reg.tx[22];
                        st_next.st = ASPRS_H_LOW;
                    end
                end
                ASPRS_H_END: begin
                    st_next.sel_n = 1'b1;
                    st_next.sdi = 1'b0;
                    st_next.rdata = st_reg.rx;
                    ev[`ASPRS_IRQ_DONE] = 1'b1;
                    st_next.st = ASPRS_H_IDLE;
                end
                default: st_next.st = st_reg.st;
            endcase
        end

        // --------------------------------------------------------------
        // APB: read data captured in setup, answer in first access cycle
        // --------------------------------------------------------------
        if (psel_in & ~penable_in) begin
            case (paddr_in)
                `ASPRS_APB_WDATA: st_next.prdata = {16'h0000, st_reg.wdata};
                `ASPRS_APB_RDATA: st_next.prdata = {16'h0000, st_reg.rdata};
                `ASPRS_APB_STATUS: begin
                    st_next.prdata = {30'h0000_0000, ~rdy_n_s,
                                      st_reg.st != ASPRS_H_IDLE};
                end
                `ASPRS_APB_IRQ_ST: st_next.prdata = {30'h0000_0000,
                                                     st_reg.irq_st};
                `ASPRS_APB_IRQ_MASK: st_next.prdata = {30'h0000_0000,
                                                       st_reg.irq_mask};
                `ASPRS_APB_PINS: st_next.prdata = {30'h0000_0000,
                                                   ~st_reg.sync_n,
                                                   ~st_reg.reset_n};
                default: st_next.prdata = 32'h0000_0000;
            endcase
        end
        if (acc & pwrite_in) begin
            case (paddr_in)
                `ASPRS_APB_CMD: begin
                    // Ignored while a frame is running
                    if (st_reg.st == ASPRS_H_IDLE) begin
                        st_next.tx = {pwdata_in[7:0], st_reg.wdata};
                        st_next.idx = 5'h00;
                        st_next.rx = 16'h0000;
                        st_next.sel_n = 1'b0;
                        st_next.div = 3'h0;
                        st_next.st = ASPRS_H_SETUP;
                    end
                end
                `ASPRS_APB_WDATA: st_next.wdata = pwdata_in[15:0];
                `ASPRS_APB_IRQ_MASK: st_next.irq_mask = pwdata_in[1:0];
                `ASPRS_APB_PINS: begin
                    st_next.reset_n = ~pwdata_in[`ASPRS_PIN_RESET];
                    st_next.sync_n = ~pwdata_in[`ASPRS_PIN_SYNC];
                end
                default: st_next.wdata = st_reg.wdata;
            endcase
        end
        if (acc & ~pwrite_in & (paddr_in == `ASPRS_APB_IRQ_ST)) begin
            // Only the bits reported are cleared; a new event still lands
            clr = st_reg.prdata[1:0];
        end
        st_next.irq_st = (st_reg.irq_st & ~clr) | ev;
        st_next.irq = |(st_next.irq_st & st_next.irq_mask);
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= host_reset();
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.device_select_n = st_reg.sel_n;
    assign link.serial_clock = st_reg.sclk;
    assign link.serial_data_in = st_reg.sdi;
    assign link.device_reset_n = st_reg.reset_n;
    assign link.filter_sync_n = st_reg.sync_n;
    assign prdata_out = st_reg.prdata;
    assign pready_out = psel_in & penable_in;
    assign pslverr_out = 1'b0;
    assign irq_out = st_reg.irq;
endmodule
`default_nettype wire

/* File: verilog/asprs_link_if.sv */
// Serial link between host controller and converter device
`timescale 1ns/1ps
`default_nettype none
interface asprs_link_if;
    logic device_select_n;
    logic serial_clock;
    logic serial_data_in;
    logic serial_data_out;
    logic device_reset_n;
    logic filter_sync_n;
    logic data_ready_n;

    modport dev (
        input device_select_n,
        input serial_clock,
        input serial_data_in,
        output serial_data_out,
        input device_reset_n,
        input filter_sync_n,
        output data_ready_n
    );

    modport host (
        output device_select_n,
        output serial_clock,
        output serial_data_in,
        input serial_data_out,
        output device_reset_n,
        output filter_sync_n,
        input data_ready_n
    );
endinterface
`default_nettype wire

/* File: verilog/asprs_pkg.sv */
// Types shared by the serial port device end and its host controller
package asprs_pkg;

    typedef enum logic {
        ASPRS_PH_CMD,
        ASPRS_PH_DATA
    } asprs_phase_t;

    typedef enum logic [2:0] {
        ASPRS_H_IDLE,
        ASPRS_H_SETUP,
        ASPRS_H_LOW,
        ASPRS_H_HIGH,
        ASPRS_H_END
    } asprs_hstate_t;

    typedef struct packed {
        asprs_phase_t phase;
        logic [3:0] bit_cnt;
        logic [15:0] in_sh;
        logic [7:0] cmd;
        logic [15:0] out_sh;
        logic sclk_d;
        logic [1:0] mode;
        logic main_en;
        logic aux_en;
        logic [11:0] rate;
        logic [15:0] main_data;
        logic [15:0] aux_data;
        logic [15:0] coef;
        logic flag_a;
        logic flag_b;
        logic cal_hold;
        logic [15:0] conv_cnt;
        logic rdy_n;
    } asprs_dev_state_t;

    typedef struct packed {
        asprs_hstate_t st;
        logic [2:0] div;
        logic sel_n;
        logic sclk;
        logic sdi;
        logic [4:0] idx;
        logic [23:0] tx;
        logic [15:0] rx;
        logic [15:0] rdata;
        logic [15:0] wdata;
        logic reset_n;
        logic sync_n;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
        logic [31:0] prdata;
        logic rdy_d;
        logic irq;
    } asprs_host_state_t;

endpackage

/* File: verilog/asprs_sync2.sv */
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module asprs_sync2 #(
    parameter int W = 1
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    import asprs_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } asprs_sync_state_t;

    asprs_sync_state_t st_reg;
    asprs_sync_state_t st_next;

    always_comb begin
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
    end

    // Idles high: every pin crossing here except the serial data lines is an active-low or idle-high line
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.s2;
endmodule
`default_nettype wire
